// File: hw/apc_map.svh
`ifndef APC_MAP_SVH
`define APC_MAP_SVH
// ----------------------------------------------------------------
// device register offsets
// ----------------------------------------------------------------
`define APC_CFG 8'h00
`define APC_RATIO 8'h04
`define APC_ROUTE 8'h08
`define APC_STAT 8'h0c
`define APC_ADCW 8'h10
`define APC_DAC1W 8'h14
`define APC_DAC2W 8'h18
// cfg fields: port one at the base bit, port two one above; auto is a single bit for both ports
`define APC_CFG_SPD 0
`define APC_CFG_MST 2
`define APC_CFG_SRC 4
`define APC_CFG_AUTO 6
// route fields: output, input one, input two port selects, then clock selects
`define APC_ROUTE_PORT 0
`define APC_ROUTE_MCLK 3
`define APC_CFG_RST 7'h00
`define APC_RATIO_RST 4'h0
`define APC_ROUTE_RST 6'h00
// ----------------------------------------------------------------
// ratio constants
// ----------------------------------------------------------------
`define APC_R128 11'd128
`define APC_R192 11'd192
`define APC_R256 11'd256
`define APC_R384 11'd384
`define APC_R512 11'd512
`define APC_R768 11'd768
`define APC_CNT_MAX 11'h7ff
// master clock edges (after halving) per generated bit clock
`define APC_PER_SS 3'd4
`define APC_PER_SS3 3'd6
`define APC_PER_DS 3'd2
`define APC_PER_DS3 3'd3
// ----------------------------------------------------------------
// controller register offsets
// ----------------------------------------------------------------
`define APC_H_CTL 8'h00
`define APC_H_DIV 8'h04
`define APC_H_ROUTE 8'h08
`define APC_H_TX1 8'h0c
`define APC_H_TX2 8'h10
`define APC_H_RX 8'h14
`define APC_H_CTL_RST 3'h0
`define APC_H_DIV_RST 24'h400421
`define APC_H_ROUTE_RST 3'h0
`endif

// File: hw/apc_pkg.sv
package apc_pkg;
   // mode pin code {mode_pin_low, mode_pin_high}
   typedef enum logic [1:0] {
      APC_HW_MSS = 2'b00,
      APC_HW_MDS = 2'b01,
      APC_HW_RSV = 2'b10,
      APC_HW_SLV = 2'b11
   } apc_hwcfg_t;
endpackage

// File: hw/apc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface apc_link_if;
   logic first_master_clock;
   logic second_master_clock;
   logic [1:0] dev_bclk_o;
   logic [1:0] dev_bclk_oe_n;
   logic [1:0] dev_fclk_o;
   logic [1:0] dev_fclk_oe_n;
   logic [1:0] host_bclk_o;
   logic [1:0] host_bclk_oe_n;
   logic [1:0] host_fclk_o;
   logic [1:0] host_fclk_oe_n;
   logic serial_audio_output;
   logic serial_audio_input_one;
   logic serial_audio_input_two;
   logic bit_clock_port_one;
   logic bit_clock_port_two;
   logic frame_clock_port_one;
   logic frame_clock_port_two;
   // ----------------------------------------------------------------
   // wire levels: device first, then controller, else low
   // ----------------------------------------------------------------
   assign bit_clock_port_one = !dev_bclk_oe_n[0] ? dev_bclk_o[0] : (!host_bclk_oe_n[0] & host_bclk_o[0]);
   assign bit_clock_port_two = !dev_bclk_oe_n[1] ? dev_bclk_o[1] : (!host_bclk_oe_n[1] & host_bclk_o[1]);
   assign frame_clock_port_one = !dev_fclk_oe_n[0] ? dev_fclk_o[0] : (!host_fclk_oe_n[0] & host_fclk_o[0]);
   assign frame_clock_port_two = !dev_fclk_oe_n[1] ? dev_fclk_o[1] : (!host_fclk_oe_n[1] & host_fclk_o[1]);
   modport device (
      input first_master_clock, second_master_clock, serial_audio_input_one, serial_audio_input_two,
      input bit_clock_port_one, bit_clock_port_two, frame_clock_port_one, frame_clock_port_two,
      output dev_bclk_o, dev_bclk_oe_n, dev_fclk_o, dev_fclk_oe_n, serial_audio_output
   );
   modport host (
      input serial_audio_output,
      input bit_clock_port_one, bit_clock_port_two, frame_clock_port_one, frame_clock_port_two,
      output host_bclk_o, host_bclk_oe_n, host_fclk_o, host_fclk_oe_n,
      output first_master_clock, second_master_clock, serial_audio_input_one, serial_audio_input_two
   );
endinterface
`default_nettype wire

// File: hw/apc_device.sv
`include "apc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module apc_device
   import apc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   apc_link_if.device link,
   input wire logic hw_mode,
   input wire logic mode_pin_low,
   input wire logic mode_pin_high,
   input wire logic clock_halving_pin,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // ----------------------------------------------------------------
   // registers and shared signals
   // ----------------------------------------------------------------
   logic [6:0] cfg_r;
   logic [3:0] ratio_r;
   logic [5:0] route_r;
   logic [31:0] adc_word_r;
   logic [31:0] adc_sh_r;
   logic serial_audio_output_r;
   logic [1:0] mclk_p_r;
   logic [1:0] medge;
   logic [1:0] pin_b;
   logic [1:0] pin_f;
   logic [1:0] brise;
   logic [1:0] fstart;
   logic [1:0] det_ds;
   logic [1:0] det_ok;
   logic [1:0] is_master;
   logic [1:0] speed_ds;
   logic [1:0] use_second_master_clock;
   logic [1:0] halve;
   logic [1:0] odd;
   logic [1:0][31:0] dac_word;
   logic [1:0] sdin;
   logic async_mode;
   logic hw_rsv;
   apc_hwcfg_t hwcfg;

   assign pin_b = {link.bit_clock_port_two, link.bit_clock_port_one};
   assign pin_f = {link.frame_clock_port_two, link.frame_clock_port_one};
   assign sdin = {link.serial_audio_input_two, link.serial_audio_input_one};
   assign hwcfg = apc_hwcfg_t'({mode_pin_low, mode_pin_high});
   assign hw_rsv = hw_mode && (hwcfg == APC_HW_RSV);
   assign async_mode = !hw_mode && (cfg_r[`APC_CFG_SRC] != cfg_r[`APC_CFG_SRC+1]);
   assign link.serial_audio_output = serial_audio_output_r;

   // detection table: {accepted, double speed}
   function automatic logic [1:0] classify(input logic [10:0] c, input logic hw);
      classify = 2'b00;
      if (c == `APC_R128 || (!hw && c == `APC_R192)) begin
         classify = 2'b11;
      end else if (c == `APC_R256 || c == `APC_R512 || (!hw && (c == `APC_R384 || c == `APC_R768))) begin
         classify = 2'b10;
      end
   endfunction

   // ----------------------------------------------------------------
   // per port control decode
   // ----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         if (hw_mode) begin
            is_master[i] = (hwcfg == APC_HW_MSS) || (hwcfg == APC_HW_MDS);
            speed_ds[i] = (hwcfg == APC_HW_MDS) || ((hwcfg == APC_HW_SLV) && det_ds[i]);
            use_second_master_clock[i] = 1'b0;
            halve[i] = clock_halving_pin;
            odd[i] = 1'b0;
         end else begin
            is_master[i] = cfg_r[`APC_CFG_MST+i];
            speed_ds[i] = (cfg_r[`APC_CFG_AUTO] && !cfg_r[`APC_CFG_MST+i]) ? det_ds[i] : cfg_r[`APC_CFG_SPD+i];
            use_second_master_clock[i] = async_mode && cfg_r[`APC_CFG_SRC+i];
            halve[i] = use_second_master_clock[i] ? ratio_r[3] : ratio_r[1];
            odd[i] = use_second_master_clock[i] ? ratio_r[2] : ratio_r[0];
         end
      end
   end

   // master clock edge detect
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mclk_p_r <= 2'b00;
      end else begin
         mclk_p_r <= {link.second_master_clock, link.first_master_clock};
      end
   end
   assign medge = {link.second_master_clock, link.first_master_clock} & ~mclk_p_r;

   // ----------------------------------------------------------------
   // per port clock generation, edge detect and speed detection
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 2; i++) begin : g_port
      logic half_r;
      logic [2:0] div_r;
      logic [5:0] bcnt_r;
      logic bo_r;
      logic fo_r;
      logic oe_n_r;
      logic pb_r;
      logic pf_r;
      logic [10:0] mcnt_r;
      logic ds_r;
      logic ok_r;
      logic mck_e;
      logic eff_e;
      logic [2:0] per;
      logic [2:0] hi;
      logic lb;
      logic lf;
      logic [1:0] cls;

      assign mck_e = use_second_master_clock[i] ? medge[1] : medge[0];
      assign eff_e = mck_e && (!halve[i] || half_r);
      assign per = speed_ds[i] ? (odd[i] ? `APC_PER_DS3 : `APC_PER_DS) : (odd[i] ? `APC_PER_SS3 : `APC_PER_SS);
      assign hi = 3'((per + 3'd1) >> 1);
      assign lb = is_master[i] ? bo_r : pin_b[i];
      assign lf = is_master[i] ? fo_r : pin_f[i];
      assign brise[i] = lb && !pb_r;
      assign fstart[i] = !lf && pf_r;
      assign cls = classify(mcnt_r, hw_mode);
      assign det_ds[i] = ds_r;
      assign det_ok[i] = ok_r;
      assign link.dev_bclk_o[i] = bo_r;
      assign link.dev_fclk_o[i] = fo_r;
      assign link.dev_bclk_oe_n[i] = oe_n_r;
      assign link.dev_fclk_oe_n[i] = oe_n_r;

      // divider: 64 bit clocks per frame, ratio = per * 64 (x2 halved)
      always_ff @(posedge sys_clk) begin
         if (rst || !is_master[i]) begin
            half_r <= 1'b0;
            div_r <= 3'h0;
            bcnt_r <= 6'h00;
         end else begin
            if (mck_e) begin
               half_r <= !half_r;
            end
            if (eff_e) begin
               if (div_r >= per - 3'd1) begin
                  div_r <= 3'h0;
                  bcnt_r <= bcnt_r + 6'd1;
               end else begin
                  div_r <= div_r + 3'd1;
               end
            end
         end
      end

      // pin drivers: enabled only in master role
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            bo_r <= 1'b0;
            fo_r <= 1'b0;
            oe_n_r <= 1'b1;
         end else begin
            bo_r <= is_master[i] && (div_r < hi);
            fo_r <= is_master[i] && bcnt_r[5];
            oe_n_r <= !is_master[i];
         end
      end

      // edge history and ratio measurement between frame starts
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            pb_r <= 1'b0;
            pf_r <= 1'b0;
            mcnt_r <= 11'h000;
            ds_r <= 1'b0;
            ok_r <= 1'b0;
         end else begin
            pb_r <= lb;
            pf_r <= lf;
            if (fstart[i]) begin
               mcnt_r <= {10'h000, mck_e};
               ok_r <= cls[1];
               if (cls[1]) begin
                  ds_r <= cls[0];
               end
            end else if (mck_e && mcnt_r != `APC_CNT_MAX) begin
               mcnt_r <= mcnt_r + 11'd1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // converter data: output launched, inputs captured on bit rise
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         adc_sh_r <= 32'h0;
         serial_audio_output_r <= 1'b0;
      end else if (brise[route_r[`APC_ROUTE_PORT]]) begin
         if (fstart[route_r[`APC_ROUTE_PORT]]) begin
            serial_audio_output_r <= adc_word_r[31];
            adc_sh_r <= {adc_word_r[30:0], 1'b0};
         end else begin
            serial_audio_output_r <= adc_sh_r[31];
            adc_sh_r <= {adc_sh_r[30:0], 1'b0};
         end
      end
   end

   for (genvar j = 0; j < 2; j++) begin : g_dac
      logic [31:0] sh_r;
      logic [31:0] word_r;
      logic sel;
      assign sel = route_r[`APC_ROUTE_PORT+1+j];
      assign dac_word[j] = word_r;
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            sh_r <= 32'h0;
            word_r <= 32'h0;
         end else begin
            if (fstart[sel]) begin
               word_r <= sh_r;
            end
            if (brise[sel]) begin
               sh_r <= {sh_r[30:0], sdin[j]};
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cfg_r <= `APC_CFG_RST;
         ratio_r <= `APC_RATIO_RST;
         route_r <= `APC_ROUTE_RST;
         adc_word_r <= 32'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `APC_CFG: cfg_r <= reg_wdata[6:0];
            `APC_RATIO: ratio_r <= reg_wdata[3:0];
            `APC_ROUTE: route_r <= reg_wdata[5:0];
            `APC_ADCW: adc_word_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 32'h0;
      end else begin
         case (reg_addr)
            `APC_CFG: reg_rdata <= {25'h0, cfg_r};
            `APC_RATIO: reg_rdata <= {28'h0, ratio_r};
            `APC_ROUTE: reg_rdata <= {26'h0, route_r};
            `APC_STAT: reg_rdata <= {22'h0, speed_ds, is_master, hw_rsv, async_mode, det_ok, det_ds};
            `APC_ADCW: reg_rdata <= adc_word_r;
            `APC_DAC1W: reg_rdata <= dac_word[0];
            `APC_DAC2W: reg_rdata <= dac_word[1];
            default: reg_rdata <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: hw/apc_host.sv
`include "apc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module apc_host
   import apc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   apc_link_if.host link,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   // ----------------------------------------------------------------
   // registers and shared signals
   // ----------------------------------------------------------------
   logic [2:0] ctl_r;
   logic [23:0] div_r;
   logic [2:0] route_r;
   logic [1:0][31:0] tx_r;
   logic [31:0] rx_r;
   logic [31:0] rsh_r;
   logic [1:0] mck;
   logic [1:0] mr;
   logic [1:0] brise;
   logic [1:0] bfall;
   logic [1:0] fstart;
   logic [1:0] sdin;
   logic [1:0] lb;
   logic [1:0] lf;

   assign lb = {link.bit_clock_port_two, link.bit_clock_port_one};
   assign lf = {link.frame_clock_port_two, link.frame_clock_port_one};
   assign link.first_master_clock = mck[0];
   assign link.second_master_clock = mck[1];
   assign link.serial_audio_input_one = sdin[0];
   assign link.serial_audio_input_two = sdin[1];

   // ----------------------------------------------------------------
   // master clocks, port clocks and per port edge detect
   // ----------------------------------------------------------------
   for (genvar k = 0; k < 2; k++) begin : g_port
      logic [3:0] mc_r;
      logic mck_r;
      logic mr_r;
      logic e;
      logic [3:0] pd_r;
      logic [7:0] bc_r;
      logic bo_r;
      logic fo_r;
      logic oe_n_r;
      logic pb_r;
      logic pf_r;

      assign mck[k] = mck_r;
      assign mr[k] = mr_r;
      assign e = (k == 1 && ctl_r[2]) ? mr[1] : mr[0];
      assign brise[k] = lb[k] && !pb_r;
      assign bfall[k] = !lb[k] && pb_r;
      assign fstart[k] = !lf[k] && pf_r;
      assign link.host_bclk_o[k] = bo_r;
      assign link.host_fclk_o[k] = fo_r;
      assign link.host_bclk_oe_n[k] = oe_n_r;
      assign link.host_fclk_oe_n[k] = oe_n_r;

      // master clock: toggles after half period + 1 system cycles
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            mc_r <= 4'h0;
            mck_r <= 1'b0;
            mr_r <= 1'b0;
         end else if (mc_r >= div_r[4*k+:4]) begin
            mc_r <= 4'h0;
            mck_r <= !mck_r;
            mr_r <= !mck_r;
         end else begin
            mc_r <= mc_r + 4'd1;
            mr_r <= 1'b0;
         end
      end

      // bit and frame clocks counted from master clock rises
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            pd_r <= 4'h0;
            bc_r <= 8'h00;
         end else if (e) begin
            if (pd_r >= div_r[11:8] - 4'd1) begin
               pd_r <= 4'h0;
               bc_r <= (bc_r >= div_r[23:16] - 8'd1) ? 8'h00 : bc_r + 8'd1;
            end else begin
               pd_r <= pd_r + 4'd1;
            end
         end
      end

      // pin drivers and edge history
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            bo_r <= 1'b0;
            fo_r <= 1'b0;
            oe_n_r <= 1'b1;
            pb_r <= 1'b0;
            pf_r <= 1'b0;
         end else begin
            bo_r <= pd_r < 4'((div_r[11:8] + 4'd1) >> 1);
            fo_r <= bc_r >= (div_r[23:16] >> 1);
            oe_n_r <= !ctl_r[k];
            pb_r <= lb[k];
            pf_r <= lf[k];
         end
      end
   end

   // ----------------------------------------------------------------
   // data lines: drive on bit fall, sample on bit rise
   // ----------------------------------------------------------------
   for (genvar j = 0; j < 2; j++) begin : g_tx
      logic [31:0] sh_r;
      logic out_r;
      logic sel;
      assign sel = route_r[1+j];
      assign sdin[j] = out_r;
      always_ff @(posedge sys_clk) begin
         if (rst) begin
            sh_r <= 32'h0;
            out_r <= 1'b0;
         end else if (fstart[sel]) begin
            sh_r <= tx_r[j];
         end else if (bfall[sel]) begin
            out_r <= sh_r[31];
            sh_r <= {sh_r[30:0], sh_r[31]};
         end
      end
   end

   // capture of the device output
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rsh_r <= 32'h0;
         rx_r <= 32'h0;
      end else begin
         if (fstart[route_r[0]]) begin
            rx_r <= rsh_r;
         end
         if (brise[route_r[0]]) begin
            rsh_r <= {rsh_r[30:0], link.serial_audio_output};
         end
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_r <= `APC_H_CTL_RST;
         div_r <= `APC_H_DIV_RST;
         route_r <= `APC_H_ROUTE_RST;
         tx_r <= '0;
      end else if (reg_wr) begin
         case (reg_addr)
            `APC_H_CTL: ctl_r <= reg_wdata[2:0];
            `APC_H_DIV: div_r <= reg_wdata[23:0];
            `APC_H_ROUTE: route_r <= reg_wdata[2:0];
            `APC_H_TX1: tx_r[0] <= reg_wdata;
            `APC_H_TX2: tx_r[1] <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst || !reg_rd) begin
         reg_rdata <= 32'h0;
      end else begin
         case (reg_addr)
            `APC_H_CTL: reg_rdata <= {29'h0, ctl_r};
            `APC_H_DIV: reg_rdata <= {8'h0, div_r};
            `APC_H_ROUTE: reg_rdata <= {29'h0, route_r};
            `APC_H_TX1: reg_rdata <= tx_r[0];
            `APC_H_TX2: reg_rdata <= tx_r[1];
            `APC_H_RX: reg_rdata <= rx_r;
            default: reg_rdata <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

// File: tb/apc_link_props.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// link checks between the two ends
// ------------------------------------------------------------
module apc_link_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic first_master_clock,
   input wire logic [1:0] dev_bclk_o,
   input wire logic [1:0] dev_bclk_oe_n,
   input wire logic [1:0] dev_fclk_o,
   input wire logic [1:0] dev_fclk_oe_n,
   input wire logic [1:0] host_bclk_oe_n,
   input wire logic [1:0] host_fclk_oe_n,
   input wire logic serial_audio_output,
   input wire logic bit_clock_port_one,
   input wire logic bit_clock_port_two
);
   logic mck_r, bck_r, fck_r, b1_r, b2_r, live_r, mr, br, fc;
   logic [5:0] half_r;
   logic [4:0] per_r, since_r;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // edge detects on the first master clock and the device's port one drive
   assign mr = first_master_clock & !mck_r;
   assign br = dev_bclk_o[0] & !bck_r & !dev_bclk_oe_n[0];
   assign fc = (dev_fclk_o[0] != fck_r) & !dev_fclk_oe_n[0];
   // previous levels
   always_ff @(posedge sys_clk) begin
      {mck_r, bck_r, fck_r} <= {first_master_clock, dev_bclk_o[0], dev_fclk_o[0]};
      {b1_r, b2_r} <= {bit_clock_port_one, bit_clock_port_two};
   end
   // bit rises per half frame, master rises per bit; cleared when not driving
   // checks wait for a frame edge: the first bit after enable may be short
   always_ff @(posedge sys_clk) begin
      if (rst || dev_bclk_oe_n[0]) begin
         {live_r, half_r, per_r} <= '0;
      end else begin
         live_r <= live_r | fc;
         half_r <= fc ? 6'(br) : half_r + 6'(br);
         per_r <= br ? 5'(mr) : per_r + 5'(mr);
      end
   end
   // cycles since a bit clock rise on either port, saturating
   always_ff @(posedge sys_clk) begin
      if (rst || (bit_clock_port_one & !b1_r) || (bit_clock_port_two & !b2_r)) begin
         since_r <= 5'h00;
      end else if (since_r != 5'h1f) begin
         since_r <= since_r + 5'h01;
      end
   end
   reset_idle_a: assert property ($fell(rst) |-> &{dev_bclk_oe_n, dev_fclk_oe_n, host_bclk_oe_n, host_fclk_oe_n})
      else $error("pins driven after reset");
   pin_pair_a: assert property (dev_bclk_oe_n == dev_fclk_oe_n)
      else $error("bit and frame pins differ in direction");
   half_frame_a: assert property (fc && live_r |-> half_r == 6'h20)
      else $error("half frame is not 32 bit clocks");
   bit_ratio_a: assert property (br && live_r |-> per_r inside {5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c})
      else $error("master rises per bit clock not allowed");
   launch_edge_a: assert property ($changed(serial_audio_output) |-> since_r <= 5'h04)
      else $error("output data moved away from a bit clock rise");
   frame_align_a: assert property (fc |-> dev_bclk_o[0] != bck_r)
      else $error("frame clock moved off a bit boundary");
   mclk_half_a: assert property ($rose(first_master_clock) |=> first_master_clock)
      else $error("master clock high for one cycle");
   host_pair_a: assert property (host_bclk_oe_n == host_fclk_oe_n)
      else $error("controller drives one clock pin alone");
   cover property (fc && live_r);
   cover property ($changed(serial_audio_output));
   cover property (!host_bclk_oe_n[0] && mr);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {bit h; logic [31:0] e; logic [31:0] m;} apc_note_t;
   logic sys_clk, rst, hw, mlo, mhi, halv, dwr, drr, hwr, hrr;
   logic [7:0] ra;
   logic [31:0] wd, drd, hrd, w, v;
   logic [1:0] rdd;
   int fails, checked;
   int kk[5] = '{2, 5, 4, 3, 6};
   logic [31:0] ee[5] = '{32'h5, 32'h1, 32'h4, 32'h5, 32'h4};
   int rr[4] = '{2, 3, 4, 6};
   logic [1:0] cc[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
   logic [31:0] ex[4] = '{32'hc0, 32'h20, 32'hc0, 32'h0};
   apc_note_t q[$];
   apc_link_if apc_link_if_inst ();
   apc_device apc_device_inst (.sys_clk(sys_clk), .rst(rst), .link(apc_link_if_inst), .hw_mode(hw),
      .mode_pin_low(mlo), .mode_pin_high(mhi), .clock_halving_pin(halv), .reg_addr(ra), .reg_wdata(wd),
      .reg_wr(dwr), .reg_rd(drr), .reg_rdata(drd));
   apc_host apc_host_inst (.sys_clk(sys_clk), .rst(rst), .link(apc_link_if_inst), .reg_addr(ra),
      .reg_wdata(wd), .reg_wr(hwr), .reg_rd(hrr), .reg_rdata(hrd));
   apc_link_props apc_link_props_inst (.sys_clk(sys_clk), .rst(rst),
      .first_master_clock(apc_link_if_inst.first_master_clock), .dev_bclk_o(apc_link_if_inst.dev_bclk_o),
      .dev_bclk_oe_n(apc_link_if_inst.dev_bclk_oe_n), .dev_fclk_o(apc_link_if_inst.dev_fclk_o),
      .dev_fclk_oe_n(apc_link_if_inst.dev_fclk_oe_n), .host_bclk_oe_n(apc_link_if_inst.host_bclk_oe_n),
      .host_fclk_oe_n(apc_link_if_inst.host_fclk_oe_n), .serial_audio_output(apc_link_if_inst.serial_audio_output),
      .bit_clock_port_one(apc_link_if_inst.bit_clock_port_one),
      .bit_clock_port_two(apc_link_if_inst.bit_clock_port_two));
   // ------------------------------------------------------------
   // bus tasks and checking
   // ------------------------------------------------------------
   task automatic wr(input bit h, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      ra <= a;
      wd <= d;
      {hwr, dwr} <= {h, !h};
      @(posedge sys_clk);
      {hwr, dwr} <= 2'b00;
   endtask
   task automatic rd(input bit h, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge sys_clk);
      ra <= a;
      {hrr, drr} <= {h, !h};
      q.push_back('{h, e, m});
      @(posedge sys_clk);
      {hrr, drr} <= 2'b00;
   endtask
   task automatic cmp(input logic [31:0] got);
      apc_note_t n;
      n = q.pop_front();
      checked++;
      if ((got & n.m) !== n.e) begin
         fails++;
         $display("unexpected at %0t got %h expected %h", $time, got & n.m, n.e);
      end
   endtask
   task automatic close_out();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // read data watcher, one cycle after each read strobe
   always @(posedge sys_clk) begin
      rdd <= {hrr, drr};
      if (rdd != 2'b00) cmp(rdd[1] ? hrd : drd);
   end
   // hang guard
   initial begin
      repeat (90000) @(posedge sys_clk);
      fails++;
      close_out();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {hw, mlo, mhi, halv, dwr, drr, hwr, hrr} = '0;
      ra = '0;
      wd = '0;
      void'($urandom(16));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      // reset values and unmapped places
      rd(0, 8'h00, 32'h0, '1);
      rd(0, 8'h08, 32'h0, '1);
      rd(0, 8'h20, 32'h0, '1);
      rd(1, 8'h04, 32'h00400421, '1);
      rd(1, 8'h30, 32'h0, '1);
      w = $urandom();
      wr(0, 8'h10, w);
      rd(0, 8'h10, w, '1);
      // controller drives both ports, device detects the speed
      v = $urandom();
      wr(1, 8'h0c, v);
      wr(1, 8'h10, ~v);
      wr(1, 8'h08, 32'h4);
      wr(0, 8'h08, 32'h4);
      wr(1, 8'h00, 32'h3);
      wr(0, 8'h00, 32'h40);
      for (int i = 0; i < 5; i++) begin
         wr(1, 8'h04, 32'h00400021 | (kk[i] << 8));
         repeat (kk[i] * 1024) @(posedge sys_clk);
         rd(0, 8'h0c, ee[i], 32'h5);
      end
      rd(0, 8'h14, {v[0], v[31:1]}, '1);
      rd(0, 8'h18, ~{v[0], v[31:1]}, '1);
      rd(1, 8'h14, {w[0], 31'h0}, '1);
      // device drives port one at every ratio code, both speeds
      wr(1, 8'h00, 32'h0);
      for (int s = 0; s < 2; s++) begin
         for (int r = 0; r < 4; r++) begin
            wr(0, 8'h00, 32'h0);
            wr(0, 8'h04, r);
            wr(0, 8'h00, 32'h4 | s);
            repeat ((1536 * rr[r]) >> s) @(posedge sys_clk);
            rd(0, 8'h0c, 32'h40 | (s << 8), 32'h3d0);
         end
      end
      // differing clock selections
      wr(0, 8'h00, 32'h20);
      rd(0, 8'h0c, 32'h10, 32'h10);
      wr(0, 8'h00, 32'h30);
      rd(0, 8'h0c, 32'h0, 32'h10);
      // pin mode ignores the selections; every code
      wr(0, 8'h00, 32'h20);
      hw <= 1'b1;
      halv <= 1'($urandom());
      for (int c = 0; c < 4; c++) begin
         {mlo, mhi} <= cc[c];
         repeat (1024) @(posedge sys_clk);
         rd(0, 8'h0c, ex[c], 32'hf0);
      end
      // pin mode detection accepts fewer ratios
      wr(1, 8'h00, 32'h1);
      for (int i = 0; i < 2; i++) begin
         wr(1, 8'h04, 32'h00400321 - (i << 8));
         repeat (4096) @(posedge sys_clk);
         rd(0, 8'h0c, i ? 32'h5 : 32'h0, i ? 32'h5 : 32'h4);
      end
      close_out();
   end
endmodule
`default_nettype wire
